// >>> vdgc_pkg.sv
// constants, carrier types and field layout for the video digitizer general control block
package vdgc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] ADDR_GEN_CTRL = 8'h0a;
	localparam logic [7:0] ADDR_PHASE = 8'h0b;
	localparam logic [7:0] ADDR_BAND_PUMP = 8'h0c;
	localparam logic [7:0] ADDR_ORDER_REV = 8'h0d;

	// field positions in general_control_one
	localparam int BIT_SPLIT = 7;
	localparam int BIT_ALIGN = 6;
	localparam int BIT_LS_POL = 5;
	localparam int BIT_HOLD_POL = 4;
	localparam int BIT_CLAMP_SRC = 3;
	localparam int BIT_CLAMP_POL = 2;
	localparam int BIT_CLK_SRC = 1;
	// field positions in the other registers
	localparam int PHASE_LSB = 3;
	localparam int BAND_LSB = 5;
	localparam int PUMP_LSB = 2;
	localparam int ORDER_WR_BIT = 4;
	localparam int ORDER_RD_BIT = 7;
	localparam int REV_LSB = 1;

	// power-up values, then phase step count and phase shift
	localparam logic [4:0] PHASE_RST = 5'h10;
	localparam logic [1:0] BAND_RST = 2'h1;
	localparam logic [2:0] PUMP_RST = 3'h1;
	localparam logic ORDER_RST = 1'b0;
	localparam int PHASE_STEPS = 32;
	localparam int PHASE_SHIFT = 5;

	// general control fields travel together
	typedef struct packed {
		logic split;
		logic align;
		logic ls_pol;
		logic hold_pol;
		logic clamp_src;
		logic clamp_pol;
		logic clk_src;
	} vdgc_gen_t;

	localparam vdgc_gen_t GEN_RST = '{split: 1'b1, align: 1'b1, ls_pol: 1'b1, hold_pol: 1'b1,
		clamp_src: 1'b0, clamp_pol: 1'b1, clk_src: 1'b0};

	// polarity-corrected, synchronised pin levels
	typedef struct packed {
		logic line;
		logic hold;
		logic clamp;
	} vdgc_pins_t;

	// internal clamp sequencer, Gray coded along idle -> wait -> clamp
	typedef enum logic [1:0] {
		CL_IDLE = 2'b00,
		CL_WAIT = 2'b01,
		CL_ON = 2'b11
	} vdgc_clamp_st_t;

endpackage

// >>> vdgc_clkgen.sv
// pixel tick and sampling strobe generator, internal loop or external pixel clock
`timescale 1ns/1ps
`default_nettype none
module vdgc_clkgen
	import vdgc_pkg::*;
#(
	parameter int PW = 16
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic lead, // line sync leading edge pulse
	input wire logic hold, // sync hold active
	input wire logic ext_sel, // use external pixel clock
	input wire logic ext_rise, // rising edge of external pixel clock
	input wire logic [11:0] divider, // loop divide ratio
	input wire logic [4:0] phase, // sampling phase code
	output logic pix_tick, // one pulse per pixel period
	output logic sample_stb // sampling instant
);

	initial begin
		if (PW < 13 || PW > 30) $error("vdgc_clkgen: PW out of range");
	end

	logic [PW-1:0] cnt_q, cnt_d, per_q, per_d, acc_q, acc_d, ecnt_q, eper_q;
	logic [PW:0] step, acc_sum, thr_w, ethr_w, per_x, wrap_lim;
	logic [PW+5:0] thr_prod, ethr_prod;
	logic wrap, cross_int, sync_ok;

	////////////////////////////////////////////////////////////////////////
	// line length in clocks; while sync hold is active line sync is ignored so the loop coasts
	assign sync_ok = lead && !hold;
	assign cnt_d = sync_ok ? '0 : cnt_q + 1'b1;
	assign per_d = sync_ok ? cnt_q + 1'b1 : per_q;

	// divide the line into ratio+1 pixels by a rate accumulator
	assign step = PW'(divider) + 1'b1;
	assign per_x = {1'b0, per_q};
	assign acc_sum = {1'b0, acc_q} + step;
	assign wrap = (per_q != '0) && (acc_sum >= per_x);
	assign acc_d = sync_ok ? '0 : (wrap ? PW'(acc_sum - per_x) : acc_sum[PW-1:0]);

	// phase threshold: phase/32 of a pixel period in accumulator units
	assign thr_prod = per_x * phase;
	assign thr_w = thr_prod[PW+5:PHASE_SHIFT];
	assign wrap_lim = thr_w + per_x;
	assign cross_int = (per_q != '0) && ((({1'b0, acc_q} < thr_w) && (acc_sum >= thr_w)) ||
		(acc_sum >= wrap_lim) || (wrap && thr_w == '0));

	// external clock: period measured in clocks, divider takes no part
	assign ethr_prod = {1'b0, eper_q} * phase;
	assign ethr_w = ethr_prod[PW+5:PHASE_SHIFT];

	////////////////////////////////////////////////////////////////////////
	// loop registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			per_q <= '0;
			acc_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			per_q <= per_d;
			acc_q <= acc_d;
		end
	end

	// external period counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ecnt_q <= '0;
			eper_q <= '0;
		end else if (ce) begin
			ecnt_q <= ext_rise ? '0 : ecnt_q + 1'b1;
			eper_q <= ext_rise ? ecnt_q + 1'b1 : eper_q;
		end
	end

	// source select; phase adjust stays live in both modes
	assign pix_tick = ext_sel ? ext_rise : wrap;
	assign sample_stb = ext_sel ? ((ethr_w == '0) ? ext_rise : (!ext_rise && ({1'b0, ecnt_q} + 1'b1 == ethr_w)))
		: cross_int;

endmodule
`default_nettype wire

// >>> vdgc_top.sv
// general control registers and pixel-path steering of the video digitizer
`timescale 1ns/1ps
`default_nettype none
module vdgc_top
	import vdgc_pkg::*;
#(
	parameter int DW = 24, // pixel word width, three channels
	parameter int PW = 16, // line length counter width in clocks
	parameter logic [2:0] DIE_REV = 3'h2 // arbitrary value
) (
	input wire logic clk, // 250 MHz system clock
	input wire logic nrst, // async reset, active low
	input wire logic ce, // clock enable, freezes all state
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data, valid cycle after strobe
	input wire logic [11:0] loop_divide_ratio, // loop divide ratio
	input wire logic [7:0] clamp_start_offset, // clamp start in pixels
	input wire logic [7:0] clamp_length, // clamp length in pixels
	input wire logic line_sync_in, // raw line sync pin
	input wire logic sync_hold_input, // raw sync hold pin
	input wire logic ext_clamp_in, // raw external clamp pin
	input wire logic external_pixel_clock_in, // external pixel clock pin
	input wire logic [DW-1:0] adc_data, // converter output, same clock
	output logic [DW-1:0] port_a_data, // Port A data
	output logic [DW-1:0] port_b_data, // Port B data
	output logic port_b_oe, // Port B output enable
	output logic output_data_clock, // output data clock
	output logic clamp_active, // clamp all channels
	output logic [4:0] sample_phase, // sampling phase code
	output logic [1:0] osc_band_sel, // oscillator band
	output logic [2:0] pump_code, // charge-pump current code
	output logic pixel_clock_sel // 1 selects external pixel clock
);

	initial begin
		if (DW < 1) $error("vdgc_top: DW must be positive");
	end

	////////////////////////////////////////////////////////////////////////
	// register file
	vdgc_gen_t gen_q;
	logic [4:0] phase_q;
	logic [1:0] band_q;
	logic [2:0] pump_q;
	logic order_q;
	logic [7:0] rdata_q;
	logic [7:0] rd_mux;
	logic wr_gen, wr_phase, wr_band, wr_order;

	// one decode used by both the write strobes and the read mux
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr_gen = ce && reg_wr && hit(reg_addr, ADDR_GEN_CTRL);
	assign wr_phase = ce && reg_wr && hit(reg_addr, ADDR_PHASE);
	assign wr_band = ce && reg_wr && hit(reg_addr, ADDR_BAND_PUMP);
	assign wr_order = ce && reg_wr && hit(reg_addr, ADDR_ORDER_REV);

	// writes store only the defined fields; reserved bits are dropped
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gen_q <= GEN_RST;
			phase_q <= PHASE_RST;
			band_q <= BAND_RST;
			pump_q <= PUMP_RST;
			order_q <= ORDER_RST;
		end else begin
			if (wr_gen) gen_q <= reg_wdata[BIT_SPLIT:BIT_CLK_SRC];
			if (wr_phase) phase_q <= reg_wdata[PHASE_LSB +: 5];
			if (wr_band) band_q <= reg_wdata[BAND_LSB +: 2];
			if (wr_band) pump_q <= reg_wdata[PUMP_LSB +: 3];
			if (wr_order) order_q <= reg_wdata[ORDER_WR_BIT];
		end
	end

	// read mux: port order comes back in bit 7, revision is read-only, others zero
	assign rd_mux = hit(reg_addr, ADDR_GEN_CTRL) ? {gen_q, 1'b0} :
		hit(reg_addr, ADDR_PHASE) ? {phase_q, 3'h0} :
		hit(reg_addr, ADDR_BAND_PUMP) ? {1'b0, band_q, pump_q, 2'h0} :
		hit(reg_addr, ADDR_ORDER_REV) ? {order_q, 3'h0, DIE_REV, 1'b0} :
		8'h00;

	// read data register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) rdata_q <= 8'h00;
		else if (ce && reg_rd) rdata_q <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only the second stage is read
	localparam int NSYNC = 4;
	logic [NSYNC-1:0] pin_raw, s1_q, s2_q;
	vdgc_pins_t act, act_prev_q;
	logic eck_prev_q;
	logic line_lead, line_trail, ext_rise;

	assign pin_raw = {external_pixel_clock_in, ext_clamp_in, sync_hold_input, line_sync_in};

	generate
		for (genvar i = 0; i < NSYNC; i++) begin : g_sync
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
				end else if (ce) begin
					s1_q[i] <= pin_raw[i];
					s2_q[i] <= s1_q[i];
				end
			end
		end
	endgenerate

	// polarity correction to active-high before any edge detection
	assign act.line = ~(s2_q[0] ^ gen_q.ls_pol);
	assign act.hold = ~(s2_q[1] ^ gen_q.hold_pol);
	assign act.clamp = ~(s2_q[2] ^ gen_q.clamp_pol);

	// edge history
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_prev_q <= '0;
			eck_prev_q <= 1'b0;
		end else if (ce) begin
			act_prev_q <= act;
			eck_prev_q <= s2_q[3];
		end
	end

	// leading edge times sampling, trailing edge times clamp placement
	assign line_lead = act.line && !act_prev_q.line;
	assign line_trail = !act.line && act_prev_q.line;
	assign ext_rise = s2_q[3] && !eck_prev_q;

	////////////////////////////////////////////////////////////////////////
	// clock generator
	logic pix_tick, sample_stb;

	vdgc_clkgen #(
		.PW(PW)
	) u_clkgen (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.lead(line_lead),
		.hold(act.hold),
		.ext_sel(gen_q.clk_src),
		.ext_rise(ext_rise),
		.divider(loop_divide_ratio),
		.phase(phase_q),
		.pix_tick(pix_tick),
		.sample_stb(sample_stb)
	);

	////////////////////////////////////////////////////////////////////////
	// internal clamp sequencer counted in pixel periods from the trailing edge
	vdgc_clamp_st_t cl_q, cl_d;
	logic [7:0] ccnt_q, ccnt_d;
	logic [7:0] ccnt_inc;
	logic clamp_d;

	assign ccnt_inc = ccnt_q + 8'h01;

	// zero offset or length is unsupported; the counter then runs a full 256 wrap
	always_comb begin
		cl_d = cl_q;
		ccnt_d = ccnt_q;
		case (cl_q)
			CL_IDLE: begin
				ccnt_d = 8'h00;
			end
			CL_WAIT: begin
				if (pix_tick) begin
					ccnt_d = ccnt_inc;
					if (ccnt_inc == clamp_start_offset) begin
						cl_d = CL_ON;
						ccnt_d = 8'h00;
					end
				end
			end
			CL_ON: begin
				if (pix_tick) begin
					ccnt_d = ccnt_inc;
					if (ccnt_inc == clamp_length) begin
						cl_d = CL_IDLE;
						ccnt_d = 8'h00;
					end
				end
			end
			default: begin
				cl_d = CL_IDLE;
				ccnt_d = 8'h00;
			end
		endcase
		if (line_trail) begin
			cl_d = CL_WAIT;
			ccnt_d = 8'h00;
		end
	end

	// sequencer registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cl_q <= CL_IDLE;
			ccnt_q <= 8'h00;
		end else if (ce) begin
			cl_q <= cl_d;
			ccnt_q <= ccnt_d;
		end
	end

	// clamp source select
	assign clamp_d = gen_q.clamp_src ? act.clamp : (cl_q == CL_ON);

	////////////////////////////////////////////////////////////////////////
	// output steering
	logic odd_q, dck_q, b_oe_q, clamp_q;
	logic [DW-1:0] a_q, b_q, hold_q;
	logic to_b, dual_align;

	// port order and alignment only count in dual-port mode
	assign to_b = gen_q.split && (odd_q ^ order_q);
	assign dual_align = gen_q.split && gen_q.align;

	// odd_q is 0 when the next sample is first of a pair; leading edge restarts the count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			odd_q <= 1'b0;
		end else if (ce) begin
			if (line_lead) odd_q <= 1'b0;
			else if (sample_stb) odd_q <= gen_q.split & ~odd_q;
		end
	end

	// data ports: aligned mode holds the first sample so both ports change together,
	// which delays Port A, or Port B when order_q is set, by half a data clock period
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			a_q <= '0;
			b_q <= '0;
			hold_q <= '0;
		end else if (ce && sample_stb) begin
			if (!gen_q.split) begin
				a_q <= adc_data;
			end else if (dual_align) begin
				if (!odd_q) hold_q <= adc_data;
				else begin
					a_q <= order_q ? adc_data : hold_q;
					b_q <= order_q ? hold_q : adc_data;
				end
			end else if (to_b) begin
				b_q <= adc_data;
			end else begin
				a_q <= adc_data;
			end
		end
	end

	// data clock: falls as the pair changes in aligned mode, otherwise toggles per sample
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dck_q <= 1'b0;
			b_oe_q <= 1'b0;
			clamp_q <= 1'b0;
		end else if (ce) begin
			b_oe_q <= gen_q.split;
			clamp_q <= clamp_d;
			if (sample_stb) dck_q <= dual_align ? ~odd_q : ~dck_q;
		end
	end

	assign reg_rdata = rdata_q;
	assign port_a_data = a_q;
	assign port_b_data = b_q;
	assign port_b_oe = b_oe_q;
	assign output_data_clock = dck_q;
	assign clamp_active = clamp_q;
	assign sample_phase = phase_q;
	assign osc_band_sel = band_q;
	assign pump_code = pump_q;
	assign pixel_clock_sel = gen_q.clk_src;

	////////////////////////////////////////////////////////////////////////
	// checks
	logic seen_wr_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) seen_wr_q <= 1'b0;
		else if (ce && reg_wr) seen_wr_q <= 1'b1;
	end

	single_port_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && sample_stb && !gen_q.split |=> port_a_data == $past(adc_data))
		else $error("single-port sample not on Port A");

	port_b_hiz_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && !gen_q.split |=> !port_b_oe)
		else $error("Port B driven in single-port mode");

	power_up_a: assert property (@(posedge clk) disable iff (!nrst)
		!seen_wr_q |-> gen_q == GEN_RST && sample_phase == PHASE_RST)
		else $error("power-up field values wrong");

	aligned_clk_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && sample_stb && dual_align && odd_q |=> !output_data_clock
			&& (($past(order_q) ? port_a_data : port_b_data) == $past(adc_data, 1)))
		else $error("aligned pair not presented together");

	ext_clamp_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && gen_q.clamp_src |=> clamp_active == ~($past(s2_q[2]) ^ $past(gen_q.clamp_pol)))
		else $error("external clamp polarity wrong");

	first_pixel_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && sample_stb && !odd_q && gen_q.split && !order_q && !gen_q.align
			|=> $stable(port_b_data))
		else $error("first sample after leading edge not on Port A");

	order_readback_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && reg_rd && reg_addr == ADDR_ORDER_REV |=> reg_rdata[7] == $past(order_q)
			&& reg_rdata[6:4] == 3'h0 && reg_rdata[3:1] == DIE_REV)
		else $error("port order readback misplaced");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && reg_rd && reg_addr == ADDR_GEN_CTRL |=> reg_rdata[0] == 1'b0)
		else $error("reserved bit reads nonzero");

	clamp_start_a: assert property (@(posedge clk) disable iff (!nrst)
		ce && cl_q == CL_WAIT && cl_d == CL_ON |-> pix_tick && ccnt_inc == clamp_start_offset)
		else $error("internal clamp started at wrong pixel");

	cov_dual_align: cover property (@(posedge clk) disable iff (!nrst) ce && sample_stb && dual_align && odd_q);
	cov_int_clamp: cover property (@(posedge clk) disable iff (!nrst) cl_q == CL_WAIT ##1 cl_q == CL_ON);
	cov_sync_hold_input: cover property (@(posedge clk) disable iff (!nrst) line_lead && act.hold);

endmodule
`default_nettype wire

// >>> vdgc_disp_model.sv
// display controller model latching the demultiplexed pixel ports
`timescale 1ns/1ps
`default_nettype none
module vdgc_disp_model #(
	parameter int DW = 24
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic output_data_clock, // data clock from the digitizer
	input wire logic port_b_oe, // Port B driven when high
	input wire logic [DW-1:0] port_a_data, // Port A pins
	input wire logic [DW-1:0] port_b_data, // Port B pins
	output logic [DW-1:0] lat_a, // last word latched from Port A
	output logic [DW-1:0] lat_b, // last word latched from Port B
	output logic [15:0] lat_cnt // number of latch edges seen
);
////////////////////////////////////////////////////////////////////////
	logic dck_q;
	logic [DW-1:0] pin_b;

	// an undriven Port B reads back inverted, so stale data never passes
	assign pin_b = port_b_oe ? port_b_data : ~lat_b;

	// one rising data clock latches both ports at once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dck_q <= 1'b0;
			lat_a <= '0;
			lat_b <= '0;
			lat_cnt <= '0;
		end else begin
			dck_q <= output_data_clock;
			if (output_data_clock && !dck_q) begin
				lat_a <= port_a_data;
				lat_b <= pin_b;
				lat_cnt <= lat_cnt + 16'h1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> vdgc_tb.sv
// self-checking testbench of the general control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import vdgc_pkg::*;
	localparam logic [2:0] REV = 3'h5; // arbitrary value
	logic clk, nrst, ce, reg_wr, reg_rd, ls, hold, eclamp, eck, ext_run;
	logic [7:0] addr, wdata, rdata, cl_off, cl_len, rd_v;
	logic [23:0] adc, pa, pb, la, lb;
	logic boe, dck, clact, ckse;
	logic [4:0] phase;
	logic [1:0] band;
	logic [2:0] pump;
	logic [15:0] lcnt, c0;
	logic [7:0] modes [4] = '{8'h76, 8'h36, 8'hf6, 8'hb6};
	int error_cnt = 0;
	int tests_run = 0;
	int n;

////////////////////////////////////////////////////////////////////////
	vdgc_top #(.DIE_REV(REV)) vdgc_top_i (.clk(clk), .nrst(nrst), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.loop_divide_ratio(12'h009), .clamp_start_offset(cl_off), .clamp_length(cl_len),
		.line_sync_in(ls), .sync_hold_input(hold), .ext_clamp_in(eclamp),
		.external_pixel_clock_in(eck), .adc_data(adc), .port_a_data(pa), .port_b_data(pb),
		.port_b_oe(boe), .output_data_clock(dck), .clamp_active(clact), .sample_phase(phase),
		.osc_band_sel(band), .pump_code(pump), .pixel_clock_sel(ckse));
	vdgc_disp_model vdgc_disp_model_i (.clk(clk), .nrst(nrst), .output_data_clock(dck),
		.port_b_oe(boe), .port_a_data(pa), .port_b_data(pb), .lat_a(la), .lat_b(lb), .lat_cnt(lcnt));

////////////////////////////////////////////////////////////////////////
	// clock, and an external pixel clock that stands still when not in use
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		eck = 1'b0;
		forever begin
			repeat (4) @(posedge clk);
			#1 eck = ext_run ? ~eck : 1'b0;
		end
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// strobes are held through the taking edge, then dropped
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		addr = a;
		wdata = d;
		cyc(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		reg_rd = 1'b1;
		addr = a;
		cyc(1);
		reg_rd = 1'b0;
		cyc(1);
		rd_v = rdata;
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog: the sequence needs about a thousand cycles
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end

////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, reg_wr, reg_rd, ls, hold, eclamp, ext_run} = '0;
		{ce, addr, wdata, adc, cl_off, cl_len} = {1'b1, 8'h00, 8'h00, 24'h0, 8'h02, 8'h03};
		cyc(8);
		nrst = 1'b1;
		cyc(2);
		// power-up values
		check({ckse, pump, band, phase, boe}, {1'b0, 3'h1, 2'h1, 5'h10, 1'b1});
		rd(8'h0a); check(rd_v, 8'hf4);
		rd(8'h0b); check(rd_v, 8'h80);
		rd(8'h0c); check(rd_v, 8'h24);
		rd(8'h0d); check(rd_v, {4'h0, REV, 1'b0});
		// reserved bits and unmapped places
		wr(8'h0a, 8'hff); rd(8'h0a); check(rd_v, 8'hfe);
		wr(8'h0b, 8'hff); rd(8'h0b); check(rd_v, 8'hf8);
		check(phase, 5'h1f);
		wr(8'h0e, 8'hff); rd(8'h0e); check(rd_v, 8'h00);
		// port order moves to bit 7 on readback
		wr(8'h0d, 8'hff); rd(8'h0d); check(rd_v, {4'h8, REV, 1'b0});
		wr(8'h0d, 8'hef); rd(8'h0d); check(rd_v, {4'h0, REV, 1'b0});
		// every band and pump code
		for (int i = 0; i < 32; i++) begin
			wr(8'h0c, 8'(i << 2) | 8'h83);
			rd(8'h0c); check(rd_v, i << 2);
			check({band, pump}, i);
		end
		// external pixel clock, phase 0, all four split and align settings
		wr(8'h0b, 8'h00);
		ext_run = 1'b1;
		foreach (modes[m]) begin
			wr(8'h0a, modes[m]);
			for (int v = 0; v < 2; v++) begin
				adc = v ? 24'h5a3c96 : 24'h81e7ff;
				ls = 1'b1; cyc(10); ls = 1'b0;
				c0 = lcnt;
				cyc(80);
				check(ckse, 1'b1);
				check(boe, modes[m][7]);
				check(la, adc);
				if (modes[m][7]) check(lb, adc);
				check(lcnt != c0, 1'b1);
			end
		end
		// internal clamp counted in pixel ticks from the line sync trailing edge
		wr(8'h0a, 8'hf6);
		ls = 1'b1; cyc(30); ls = 1'b0;
		n = 0;
		while (clact !== 1'b1 && n < 200) begin cyc(1); n++; end
		check(n >= 6 && n <= 32, 1'b1);
		n = 0;
		while (clact === 1'b1 && n < 300) begin cyc(1); n++; end
		check(n >= 16 && n <= 32, 1'b1);
		ext_run = 1'b0;
		// external clamp pin in both polarities
		for (int p = 0; p < 2; p++) begin
			wr(8'h0a, p ? 8'hfc : 8'hf8);
			for (int l = 0; l < 2; l++) begin
				eclamp = l[0];
				cyc(6);
				check(clact, l == p);
			end
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
